// ### dv/otp_port_checker_assertions.sv
// Port-level assertions for the OTP program and verify port
`timescale 1ns/10ps
module otp_port_checker (
  input wire logic       pclk,                // Clock
  input wire logic       presetn,             // Async reset, active low
  input wire logic       psel,                // APB select
  input wire logic       penable,             // APB enable
  input wire logic [7:0] paddr,               // APB byte address
  input wire logic       pready,              // APB ready
  input wire logic       pslverr,             // APB error
  input wire logic       programming_voltage, // Supply at program level
  input wire logic       sel_a,               // Mode select a
  input wire logic       p0_oe_n              // Port 0 drive, low drives
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Bus phases and decoded map
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence access_s;
    psel && penable;
  endsequence
  logic mapped;
  assign mapped = paddr inside {8'h00, 8'h04, 8'h08};

  AST_READY_WAIT: assert property (setup_s ##1 access_s |-> !pready ##1 pready)
    else $error("pready not in second access cycle");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_READY_CAUSE: assert property (pready |-> access_s ##0 $past(penable))
    else $error("pready outside an access phase");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_UNMAPPED_ERR: assert property (pready && !mapped |-> pslverr)
    else $error("unmapped access not flagged");
  AST_MAPPED_OK: assert property (pready && mapped |-> !pslverr)
    else $error("mapped access flagged");
  AST_PROG_NO_DRIVE: assert property (programming_voltage [*4] |-> p0_oe_n)
    else $error("port 0 driven in program mode");
  AST_SEL_A_NO_DRIVE: assert property (sel_a [*4] |-> p0_oe_n)
    else $error("port 0 driven with sel_a high");
endmodule : otp_port_checker

bind otp_program_verify_port otp_port_checker u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .programming_voltage(programming_voltage), .sel_a(sel_a),
  .p0_oe_n(p0_oe_n)
);

// ### dv/otp_program_verify_port_bench.sv
// Self-checking bench for the OTP program and verify port
`timescale 1ns/10ps
`include "otp_params.svh"
module otp_program_verify_port_bench;
  localparam logic [3:0] CODE = 4'hB, ENC = 4'hA, LK1 = 4'hF, LK2 = 4'hC;
  localparam logic [3:0] VER  = 4'h3, SIG = 4'h0;
  localparam logic [7:0] MAKER = 8'hA5, PART = 8'h5A; // Arbitrary values
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, p1_in, p0_in, p0_out;
  logic [31:0] pwdata, prdata;
  logic [5:0]  p2_in;
  logic        rst_pin, fetch_strobe_n, prog_strobe, supply_select;
  logic        programming_voltage, sel_a, sel_b, sel_c, sel_d, p0_oe_n;
  int          errors = 0, num_checks = 0, cycles = 0;

  otp_program_verify_port #(.AW(6), .MAKER_CODE(MAKER), .PART_CODE(PART)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rst_pin(rst_pin),
    .fetch_strobe_n(fetch_strobe_n), .prog_strobe(prog_strobe),
    .supply_select(supply_select), .programming_voltage(programming_voltage),
    .sel_a(sel_a), .sel_b(sel_b), .sel_c(sel_c), .sel_d(sel_d),
    .p1_in(p1_in), .p2_in(p2_in), .p0_in(p0_in), .p0_out(p0_out),
    .p0_oe_n(p0_oe_n));

  otp_programmer prog (
    .pclk(pclk), .rst_pin(rst_pin), .fetch_strobe_n(fetch_strobe_n),
    .prog_strobe(prog_strobe), .supply_select(supply_select),
    .programming_voltage(programming_voltage), .sel_a(sel_a), .sel_b(sel_b),
    .sel_c(sel_c), .sel_d(sel_d), .p1_in(p1_in), .p2_in(p2_in),
    .p0_in(p0_in), .p0_out(p0_out), .p0_oe_n(p0_oe_n));

  // Clock, 100 ns period
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // Hang guard
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 60000) begin
      errors++;
      finish_test();
    end
  end

  task automatic finish_test;
    if (errors == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One APB transfer, held until pready
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rreg(input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, a, 32'h0, rd, err);
    check(rd & m, e);
  endtask : rreg

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, a, d, rd, err);
  endtask : wreg

  task automatic vchk(input logic [13:0] a, input logic [3:0] s,
                      input logic [7:0] ev, input logic eo);
    logic [7:0] v;
    prog.read_byte(a, s, v);
    check({24'h0, v}, {24'h0, ev});
    check({31'h0, p0_oe_n}, {31'h0, eo});
  endtask : vchk

  // Main sequence
  initial begin
    logic [31:0] rd;
    logic        err;
    presetn = 1'b0;
    {psel, penable, pwrite} = 3'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rreg(`ADDR_CTRL, 32'h3, 32'h1);
    rreg(`ADDR_STATUS, 32'h3F, 32'h0);
    rreg(`ADDR_COUNT, 32'hFFFF_FFFF, 32'h0);
    apb(1'b0, 8'h0C, 32'h0, rd, err);
    check({rd[31:1], err}, 32'h1);
    vchk(14'h3, VER, 8'hFF, 1'b0);
    prog.program_byte(14'h5, 8'h3C, CODE, 1000, 100);
    vchk(14'h5, VER, 8'h3C, 1'b0);
    rreg(`ADDR_STATUS, 32'h18, 32'h0);
    rreg(`ADDR_COUNT, 32'hFFFF_0000, 32'h0001_0000);
    prog.program_byte(14'h5, 8'hF0, CODE, 10, 10);
    vchk(14'h5, VER, 8'h30, 1'b0);
    rreg(`ADDR_STATUS, 32'h10, 32'h10);
    wreg(`ADDR_STATUS, 32'h10);
    rreg(`ADDR_STATUS, 32'h10, 32'h0);
    vchk(14'h30, SIG, MAKER, 1'b0);
    vchk(14'h31, SIG, PART, 1'b0);
    prog.program_byte(14'h5, 8'h0F, ENC, 10, 10);
    prog.program_byte(14'h25, 8'h00, ENC, 10, 10);
    rreg(`ADDR_STATUS, 32'h1C, 32'h1C);
    wreg(`ADDR_STATUS, 32'h18);
    vchk(14'h5, VER, 8'hC0, 1'b0);
    prog.program_byte(14'h0, 8'h00, LK1, 10, 10);
    prog.program_byte(14'h6, 8'h00, CODE, 10, 10);
    rreg(`ADDR_STATUS, 32'hB, 32'h9);
    vchk(14'h6, VER, 8'hFF, 1'b0);
    prog.program_byte(14'h0, 8'h00, LK2, 10, 10);
    rreg(`ADDR_STATUS, 32'h3, 32'h3);
    vchk(14'h5, VER, 8'hFF, 1'b1);
    wreg(`ADDR_CTRL, 32'h3);
    do apb(1'b0, `ADDR_CTRL, 32'h0, rd, err); while (rd[1] !== 1'b0);
    do apb(1'b0, `ADDR_STATUS, 32'h0, rd, err); while (rd[5] !== 1'b0);
    rreg(`ADDR_STATUS, 32'h7, 32'h0);
    vchk(14'h5, VER, 8'hFF, 1'b0);
    @(posedge pclk);
    prog.rst_pin <= 1'b0;
    vchk(14'h5, VER, 8'hFF, 1'b1);
    finish_test();
  end
endmodule : otp_program_verify_port_bench

// ### dv/otp_programmer.sv
// Programming system model driving mode pins, address and port 0
`timescale 1ns/10ps
module otp_programmer (
  input  wire logic       pclk,                // Clock
  output logic            rst_pin,             // Reset pin level
  output logic            fetch_strobe_n,      // Fetch strobe pin
  output logic            prog_strobe,         // Programming strobe
  output logic            supply_select,       // Supply logic high
  output logic            programming_voltage, // Supply at program level
  output logic            sel_a,               // Mode select a
  output logic            sel_b,               // Mode select b
  output logic            sel_c,               // Mode select c
  output logic            sel_d,               // Mode select d
  output logic      [7:0] p1_in,               // Address low byte
  output logic      [5:0] p2_in,               // Address high bits
  output logic      [7:0] p0_in,               // Port 0 wire level
  input  wire logic [7:0] p0_out,              // Device drive value
  input  wire logic       p0_oe_n              // Device drive, low drives
);
  logic [7:0] drv_q;  // Programmer data byte
  logic       drv_en; // Programmer drives port 0

  // Port 0 wire: device, else programmer, else pull-ups
  assign p0_in = !p0_oe_n ? p0_out : (drv_en ? drv_q : 8'hFF);

  // Idle levels at time zero
  initial begin
    rst_pin = 1'b1;
    fetch_strobe_n = 1'b0;
    prog_strobe = 1'b1;
    supply_select = 1'b1;
    programming_voltage = 1'b0;
    {sel_a, sel_b, sel_c, sel_d} = 4'h0;
    {p2_in, p1_in} = 14'h0;
    drv_q = 8'h00;
    drv_en = 1'b0;
  end

  // One byte: setup, 25 strobe pulses, hold
  task automatic program_byte(input logic [13:0] a, input logic [7:0] d,
                              input logic [3:0] s, input int lo, input int hi);
    @(posedge pclk);
    {p2_in, p1_in} <= a;
    drv_q <= d;
    drv_en <= 1'b1;
    {sel_a, sel_b, sel_c, sel_d} <= s;
    programming_voltage <= 1'b1;
    repeat (48) @(posedge pclk);
    repeat (25) begin
      prog_strobe <= 1'b0;
      repeat (lo) @(posedge pclk);
      prog_strobe <= 1'b1;
      repeat (hi) @(posedge pclk);
    end
    repeat (48) @(posedge pclk);
    drv_en <= 1'b0;
  endtask : program_byte

  // Verify or signature read, sampled after the access time
  task automatic read_byte(input logic [13:0] a, input logic [3:0] s,
                           output logic [7:0] v);
    @(posedge pclk);
    {p2_in, p1_in} <= a;
    {sel_a, sel_b, sel_c, sel_d} <= s;
    programming_voltage <= 1'b0;
    repeat (48) @(posedge pclk);
    v = p0_in;
  endtask : read_byte
endmodule : otp_programmer

// ### src/otp_mem.sv
// Byte array with registered read data, filled with the erased value
`timescale 1ns/10ps
module otp_mem #(
  parameter int AW = 14,
  parameter int DW = 8
) (
  input  wire logic          pclk,     // Clock
  input  wire logic          we,       // Write strobe
  input  wire logic [AW-1:0] addr,     // Read and write address
  input  wire logic [DW-1:0] wdata,    // Write data
  output logic      [DW-1:0] rdata_q   // Registered read data
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  // Array starts in the erased state
  initial begin
    for (int i = 0; i < (1 << AW); i++) begin
      mem[i] = {DW{1'b1}};
    end
  end

  // Write port and registered read; plain always since the array is preset
  always @(posedge pclk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata_q <= mem[addr];
  end

endmodule : otp_mem

// ### src/otp_params.svh
// Offsets, field positions, reset values and timing counts for the OTP port
`ifndef OTP_PARAMS_SVH
`define OTP_PARAMS_SVH

// Clock and strobe timing
`define CLK_PERIOD_NS      100
`define PULSES_PER_BYTE    25
`define PROG_LOW_MIN_NS    90000
`define PROG_LOW_MAX_NS    110000
`define PROG_HIGH_MIN_NS   10000
`define PROG_LOW_MIN_CYC   ((`PROG_LOW_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PROG_LOW_MAX_CYC   (`PROG_LOW_MAX_NS / `CLK_PERIOD_NS)
`define PROG_HIGH_MIN_CYC  ((`PROG_HIGH_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Register byte offsets on the APB side
`define ADDR_CTRL          8'h00
`define ADDR_STATUS        8'h04
`define ADDR_COUNT         8'h08

// Control register fields and reset value
`define CTRL_PROG_EN       0
`define CTRL_ERASE         1
`define CTRL_RESET         1'b1

// Status register fields
`define STAT_LOCK1         0
`define STAT_LOCK2         1
`define STAT_ENC           2
`define STAT_REFUSED       3
`define STAT_TIMING        4
`define STAT_BUSY          5
`define STAT_MODE_LSB      8

// Count register fields
`define COUNT_BYTES_LSB    16

// Array constants
`define ERASED_BYTE        8'hFF
`define ENC_LAST           14'h001F
`define SIG_ADDR_MAKER     14'h0030
`define SIG_ADDR_PART      14'h0031

`endif

// ### src/otp_pkg.sv
// Types shared by the OTP program and verify port
package otp_pkg;

  // Operating mode decoded from the static pins
  typedef enum logic [2:0] {
    MODE_IDLE,
    MODE_PGM_CODE,
    MODE_PGM_ENC,
    MODE_PGM_LOCK1,
    MODE_PGM_LOCK2,
    MODE_VERIFY,
    MODE_SIGNATURE
  } mode_e;

  // Commit sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_READ,
    ST_MERGE,
    ST_ERASE
  } cmt_state_e;

endpackage : otp_pkg

// ### src/otp_program_verify_port.sv
// Parallel program and verify port of the one-time-programmable code array
//
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/10ps
`include "otp_params.svh"

module otp_program_verify_port
  import otp_pkg::*;
#(
  parameter int         AW         = 14,
  parameter logic [7:0] MAKER_CODE = 8'hA5,  // Arbitrary value
  parameter logic [7:0] PART_CODE  = 8'h5A   // Arbitrary value
) (
  input  wire logic        pclk,                // Clock, 10 MHz
  input  wire logic        presetn,             // Async reset, active low
  input  wire logic        psel,                // APB select
  input  wire logic        penable,             // APB enable
  input  wire logic        pwrite,              // APB write
  input  wire logic [7:0]  paddr,               // APB byte address
  input  wire logic [31:0] pwdata,              // APB write data
  output logic      [31:0] prdata,              // APB read data
  output logic             pready,              // APB ready
  output logic             pslverr,             // APB error
  input  wire logic        rst_pin,             // Device reset pin level
  input  wire logic        fetch_strobe_n,      // Fetch strobe pin
  input  wire logic        prog_strobe,         // Programming strobe
  input  wire logic        supply_select,       // Supply select logic high
  input  wire logic        programming_voltage, // Supply at program level
  input  wire logic        sel_a,               // Mode select a
  input  wire logic        sel_b,               // Mode select b
  input  wire logic        sel_c,               // Mode select c
  input  wire logic        sel_d,               // Mode select d
  input  wire logic [7:0]  p1_in,               // Address low byte
  input  wire logic [5:0]  p2_in,               // Address high bits
  input  wire logic [7:0]  p0_in,               // Write data in
  output logic      [7:0]  p0_out,              // Verify data out
  output logic             p0_oe_n              // Port 0 drive, low drives
);

  mode_e         mode_now;
  logic [AW-1:0] pin_addr;
  logic          armed;
  logic [4:0]    pulse_cnt;
  logic          pulse_done;
  logic          pulse_err;

  cmt_state_e    state_q;
  cmt_state_e    state_d;
  mode_e         mode_hold_q;
  mode_e         mode_hold_d;
  logic [AW-1:0] addr_hold_q;
  logic [AW-1:0] addr_hold_d;
  logic [7:0]    data_hold_q;
  logic [7:0]    data_hold_d;
  logic [AW-1:0] sweep_q;
  logic [AW-1:0] sweep_d;
  logic          lock1_q;
  logic          lock1_d;
  logic          lock2_q;
  logic          lock2_d;
  logic          enc_prog_q;
  logic          enc_prog_d;
  logic [15:0]   bytes_q;
  logic [15:0]   bytes_d;
  logic          refused_set;
  logic          erase_start;

  logic          code_we;
  logic          enc_we;
  logic [AW-1:0] mem_addr;
  logic [7:0]    code_wdata;
  logic [7:0]    enc_wdata;
  logic [7:0]    code_rdata;
  logic [7:0]    enc_rdata;

  logic          prog_en_q;
  logic          prog_en_d;
  logic          erase_pend_q;
  logic          erase_pend_d;
  logic          refused_q;
  logic          refused_d;
  logic          timing_q;
  logic          timing_d;
  logic [31:0]   prdata_d;
  logic          pready_d;
  logic          pslverr_d;
  logic          wr_fire;
  logic [31:0]   rd_mux;
  logic          mapped;

  logic [7:0]    p0_out_d;
  logic          p0_oe_n_d;

  assign pin_addr = AW'({p2_in, p1_in});  // Upper pins unused when AW < 14

  // Mode decode from the static pin levels
  always_comb begin
    mode_now = MODE_IDLE;
    if (rst_pin && !fetch_strobe_n) begin
      if (programming_voltage && sel_a) begin
        case ({sel_b, sel_c, sel_d})
          3'b011:  mode_now = MODE_PGM_CODE;
          3'b010:  mode_now = MODE_PGM_ENC;
          3'b111:  mode_now = MODE_PGM_LOCK1;
          3'b100:  mode_now = MODE_PGM_LOCK2;
          default: mode_now = MODE_IDLE;
        endcase
      end else if (!programming_voltage && supply_select && prog_strobe &&
                   !sel_a && !sel_b) begin
        if (sel_c && sel_d) begin
          mode_now = MODE_VERIFY;
        end else if (!sel_c && !sel_d) begin
          mode_now = MODE_SIGNATURE;
        end
      end
    end
  end

  // Strobes only count while a programming mode holds steady
  assign armed = prog_en_q && (state_q != ST_ERASE) &&
                 (mode_now inside {MODE_PGM_CODE, MODE_PGM_ENC,
                                   MODE_PGM_LOCK1, MODE_PGM_LOCK2});

  // Strobe pulse counter and width checker
  otp_pulse_cnt #(
    .NPULSES  (`PULSES_PER_BYTE),
    .LOW_MIN  (`PROG_LOW_MIN_CYC),
    .LOW_MAX  (`PROG_LOW_MAX_CYC),
    .HIGH_MIN (`PROG_HIGH_MIN_CYC)
  ) u_pulse (
    .pclk         (pclk),
    .presetn      (presetn),
    .strobe       (prog_strobe),
    .arm          (armed),
    .count_q      (pulse_cnt),
    .done_q       (pulse_done),
    .timing_err_q (pulse_err)
  );

  // Code array
  otp_mem #(
    .AW (AW),
    .DW (8)
  ) u_code (
    .pclk    (pclk),
    .we      (code_we),
    .addr    (mem_addr),
    .wdata   (code_wdata),
    .rdata_q (code_rdata)
  );

  // Encryption table, read into the verify XNOR and the read-modify-write merge
  otp_mem #(
    .AW (5),
    .DW (8)
  ) u_enc (
    .pclk    (pclk),
    .we      (enc_we),
    .addr    (mem_addr[4:0]),
    .wdata   (enc_wdata),
    .rdata_q (enc_rdata)
  );

  // Commit sequencer: lock handling, read-modify-write and erase sweep
  always_comb begin
    state_d     = state_q;
    mode_hold_d = mode_hold_q;
    addr_hold_d = addr_hold_q;
    data_hold_d = data_hold_q;
    sweep_d     = sweep_q;
    lock1_d     = lock1_q;
    lock2_d     = lock2_q;
    enc_prog_d  = enc_prog_q;
    bytes_d     = bytes_q;
    refused_set = 1'b0;
    erase_start = 1'b0;
    code_we     = 1'b0;
    enc_we      = 1'b0;
    mem_addr    = pin_addr;
    code_wdata  = code_rdata & data_hold_q;
    enc_wdata   = enc_rdata & data_hold_q;
    case (state_q)
      ST_IDLE: begin
        if (erase_pend_q) begin
          erase_start = 1'b1;
          sweep_d     = '0;
          state_d     = ST_ERASE;
        end else if (pulse_done) begin
          mode_hold_d = mode_now;
          addr_hold_d = pin_addr;
          data_hold_d = p0_in;
          case (mode_now)
            MODE_PGM_LOCK1: lock1_d = 1'b1;
            MODE_PGM_LOCK2: lock2_d = 1'b1;
            MODE_PGM_CODE: begin
              if (lock1_q || lock2_q) begin
                refused_set = 1'b1;
              end else begin
                state_d = ST_READ;
              end
            end
            MODE_PGM_ENC: begin
              if (lock1_q || lock2_q || pin_addr > `ENC_LAST) begin
                refused_set = 1'b1;
              end else begin
                state_d = ST_READ;
              end
            end
            default: state_d = ST_IDLE;
          endcase
        end
      end
      ST_READ: begin
        mem_addr = addr_hold_q;
        state_d  = ST_MERGE;
      end
      ST_MERGE: begin
        mem_addr = addr_hold_q;
        bytes_d  = bytes_q + 16'h0001;
        state_d  = ST_IDLE;
        if (mode_hold_q == MODE_PGM_ENC) begin
          enc_we     = 1'b1;
          enc_prog_d = 1'b1;
        end else begin
          code_we = 1'b1;
        end
      end
      ST_ERASE: begin
        mem_addr   = sweep_q;
        code_we    = 1'b1;
        enc_we     = 1'b1;
        code_wdata = `ERASED_BYTE;
        enc_wdata  = `ERASED_BYTE;
        sweep_d    = sweep_q + 1'b1;
        if (sweep_q == {AW{1'b1}}) begin
          lock1_d    = 1'b0;
          lock2_d    = 1'b0;
          enc_prog_d = 1'b0;
          state_d    = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // Commit sequencer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q     <= ST_IDLE;
      mode_hold_q <= MODE_IDLE;
      addr_hold_q <= '0;
      data_hold_q <= 8'h00;
      sweep_q     <= '0;
      lock1_q     <= 1'b0;
      lock2_q     <= 1'b0;
      enc_prog_q  <= 1'b0;
      bytes_q     <= 16'h0000;
    end else begin
      state_q     <= state_d;
      mode_hold_q <= mode_hold_d;
      addr_hold_q <= addr_hold_d;
      data_hold_q <= data_hold_d;
      sweep_q     <= sweep_d;
      lock1_q     <= lock1_d;
      lock2_q     <= lock2_d;
      enc_prog_q  <= enc_prog_d;
      bytes_q     <= bytes_d;
    end
  end

  // Port 0 drive for verify and signature reads
  always_comb begin
    p0_out_d  = 8'h00;
    p0_oe_n_d = 1'b1;
    if (state_q == ST_IDLE) begin
      if (mode_now == MODE_VERIFY && !lock2_q) begin
        p0_oe_n_d = 1'b0;
        p0_out_d  = enc_prog_q ? ~(code_rdata ^ enc_rdata)
                               : code_rdata;
      end else if (mode_now == MODE_SIGNATURE) begin
        p0_oe_n_d = 1'b0;
        if (pin_addr == `SIG_ADDR_MAKER) begin
          p0_out_d = MAKER_CODE;
        end else if (pin_addr == `SIG_ADDR_PART) begin
          p0_out_d = PART_CODE;
        end else begin
          p0_out_d = `ERASED_BYTE;
        end
      end
    end
  end

  // Port 0 registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      p0_out  <= 8'h00;
      p0_oe_n <= 1'b1;
    end else begin
      p0_out  <= p0_out_d;
      p0_oe_n <= p0_oe_n_d;
    end
  end

  // APB slave: one wait state, read mux, sticky flags
  always_comb begin
    wr_fire      = psel && penable && pready && pwrite;
    pready_d     = psel && penable && !pready;
    prdata_d     = prdata;
    pslverr_d    = 1'b0;
    prog_en_d    = prog_en_q;
    erase_pend_d = erase_pend_q & ~erase_start;
    rd_mux       = 32'h0000_0000;
    mapped       = 1'b1;
    case (paddr)
      `ADDR_CTRL: begin
        rd_mux[`CTRL_PROG_EN] = prog_en_q;
        rd_mux[`CTRL_ERASE]   = erase_pend_q;
      end
      `ADDR_STATUS: begin
        rd_mux[`STAT_LOCK1]   = lock1_q;
        rd_mux[`STAT_LOCK2]   = lock2_q;
        rd_mux[`STAT_ENC]     = enc_prog_q;
        rd_mux[`STAT_REFUSED] = refused_q;
        rd_mux[`STAT_TIMING]  = timing_q;
        rd_mux[`STAT_BUSY]    = (state_q != ST_IDLE);
        rd_mux[`STAT_MODE_LSB +: 3] = mode_now;
      end
      `ADDR_COUNT: begin
        rd_mux[4:0] = pulse_cnt;
        rd_mux[`COUNT_BYTES_LSB +: 16] = bytes_q;
      end
      default: mapped = 1'b0;
    endcase
    if (pready_d) begin
      prdata_d  = pwrite ? 32'h0000_0000 : rd_mux;
      pslverr_d = !mapped;
    end
    refused_d = refused_q;
    timing_d  = timing_q;
    if (wr_fire && paddr == `ADDR_CTRL) begin
      prog_en_d = pwdata[`CTRL_PROG_EN];
      if (pwdata[`CTRL_ERASE]) begin
        erase_pend_d = 1'b1;
      end
    end
    if (wr_fire && paddr == `ADDR_STATUS) begin
      refused_d = refused_q & ~pwdata[`STAT_REFUSED];
      timing_d  = timing_q & ~pwdata[`STAT_TIMING];
    end
    refused_d = refused_d | refused_set;   // Set wins over clear
    timing_d  = timing_d | pulse_err;
  end

  // APB registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata       <= 32'h0000_0000;
      pready       <= 1'b0;
      pslverr      <= 1'b0;
      prog_en_q    <= `CTRL_RESET;
      erase_pend_q <= 1'b0;
      refused_q    <= 1'b0;
      timing_q     <= 1'b0;
    end else begin
      prdata       <= prdata_d;
      pready       <= pready_d;
      pslverr      <= pslverr_d;
      prog_en_q    <= prog_en_d;
      erase_pend_q <= erase_pend_d;
      refused_q    <= refused_d;
      timing_q     <= timing_d;
    end
  end

endmodule : otp_program_verify_port

// ### src/otp_pulse_cnt.sv
// Counts programming strobe pulses and checks their widths
`timescale 1ns/10ps
module otp_pulse_cnt #(
  parameter int NPULSES  = 25,
  parameter int LOW_MIN  = 900,
  parameter int LOW_MAX  = 1100,
  parameter int HIGH_MIN = 100
) (
  input  wire logic       pclk,         // Clock
  input  wire logic       presetn,      // Async reset, active low
  input  wire logic       strobe,       // Programming strobe level
  input  wire logic       arm,          // Programming mode active
  output logic      [4:0] count_q,      // Pulses seen so far
  output logic            done_q,       // Last pulse has risen
  output logic            timing_err_q  // Pulse width out of range
);

  logic        strobe_prev_q;
  logic        strobe_prev_d;
  logic        low_seen_q;
  logic        low_seen_d;
  logic [10:0] width_q;
  logic [10:0] width_d;
  logic [4:0]  count_d;
  logic        done_d;
  logic        timing_err_d;
  logic        fall;
  logic        rise;

  // Edge detect, width measure and pulse count
  always_comb begin
    fall          = strobe_prev_q & ~strobe;
    rise          = ~strobe_prev_q & strobe;
    strobe_prev_d = strobe;
    low_seen_d    = low_seen_q;
    count_d       = count_q;
    done_d        = 1'b0;
    timing_err_d  = 1'b0;
    width_d       = (width_q == 11'h7FF) ? width_q : width_q + 11'h001;
    if (fall || rise) begin
      width_d = 11'h001;
    end
    if (!arm) begin
      low_seen_d = 1'b0;
      count_d    = 5'h00;
    end else if (fall) begin
      low_seen_d = 1'b1;
      if (count_q != 5'h00 && width_q < 11'(HIGH_MIN)) begin
        timing_err_d = 1'b1;
      end
    end else if (rise && low_seen_q) begin
      low_seen_d = 1'b0;
      if (width_q < 11'(LOW_MIN) || width_q > 11'(LOW_MAX)) begin
        timing_err_d = 1'b1;
      end
      if (count_q == 5'(NPULSES - 1)) begin
        count_d = 5'h00;
        done_d  = 1'b1;
      end else begin
        count_d = count_q + 5'h01;
      end
    end
  end

  // State registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strobe_prev_q <= 1'b1;
      low_seen_q    <= 1'b0;
      width_q       <= 11'h000;
      count_q       <= 5'h00;
      done_q        <= 1'b0;
      timing_err_q  <= 1'b0;
    end else begin
      strobe_prev_q <= strobe_prev_d;
      low_seen_q    <= low_seen_d;
      width_q       <= width_d;
      count_q       <= count_d;
      done_q        <= done_d;
      timing_err_q  <= timing_err_d;
    end
  end

endmodule : otp_pulse_cnt
